// [rtl/expander_params.svh]
/*
  Constants of the 8-bit I/O expander core: serial register indices,
  reset values, status register bit positions and bus register offsets.
  Assumes inclusion by bare name from the expander design files.
*/
`ifndef EXPANDER_PARAMS_SVH
`define EXPANDER_PARAMS_SVH

// Register indices carried by the byte after the target address
`define EXP_IDX_INPUT 8'h00
`define EXP_IDX_OUTPUT 8'h01
`define EXP_IDX_POLARITY 8'h02
`define EXP_IDX_DIRECTION 8'h03

// Reset values: direction 1 = input, so all pins start as inputs
`define EXP_RST_DIRECTION 8'hff
`define EXP_RST_OUTPUT 8'hff
`define EXP_RST_POLARITY 8'h00

// Target address base; the select pin fills bit 0
`define EXP_ADDR_BASE 7'h20

// Bus register byte offsets
`define EXP_OFS_INPUT 8'h00
`define EXP_OFS_OUTPUT 8'h04
`define EXP_OFS_POLARITY 8'h08
`define EXP_OFS_DIRECTION 8'h0c
`define EXP_OFS_IRQ_STATUS 8'h10
`define EXP_OFS_IRQ_ENABLE 8'h14
`define EXP_OFS_IRQ_CLEAR 8'h18

// Interrupt status bits
`define EXP_EVT_ALERT 0
`define EXP_EVT_WRITE 1
`define EXP_EVT_READ 2
`define EXP_EVT_W 3

// Bus responses
`define EXP_RESP_OKAY 2'h0
`define EXP_RESP_SLVERR 2'h2

`endif

// [rtl/expander_pkg.sv]
/*
  Types of the expander core's serial target engine.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package expander_pkg;

  // Serial target engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_TXACK
  } link_state_t;

  // Meaning of the byte being received
  typedef enum logic [1:0] {
    BK_ADDR,
    BK_INDEX,
    BK_DATA
  } byte_kind_t;

endpackage

// [rtl/i2c_target_link.sv]
/*
  Two-wire serial target engine: start/stop detection, address match,
  register index and data bytes, read bytes with controller acknowledge.
  Assumes scl and sda arrive raw from pins; the system clock oversamples them.
*/
`timescale 1ns/1ps
`default_nettype none
`include "expander_params.svh"

module i2c_target_link #(
  parameter logic [6:0] ADDR_BASE = `EXP_ADDR_BASE
) (
  input wire logic aclk,
  input wire logic soft_rst,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic addr_select,
  input wire logic [7:0] rd_data,
  output logic sda_oe,
  output logic [7:0] index,
  output logic wr_stb,
  output logic [7:0] wr_data,
  output logic rd_load,
  output logic rd_done
);

  // Synchroniser stages plus one history stage for edge finding
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  logic scl_rise, scl_fall, bus_start, bus_stop, sda_bit;
  expander_pkg::link_state_t state_q;
  expander_pkg::byte_kind_t kind_q;
  logic [2:0] cnt_q; // Bit count within a byte
  logic [7:0] sh_q; // Shift register, both directions
  logic phase_q; // Second half of an acknowledge slot
  logic ack_q; // Our ack decision, or the controller's ack
  logic rw_q; // Read bit of the address byte

  // Two flops before use; the third only remembers the old level
  always_ff @(posedge aclk) begin
    if (soft_rst) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
    end
  end

  // Line events seen by the system clock
  always_comb begin
    sda_bit = sda_sync_q[1];
    scl_rise = scl_sync_q[1] & ~scl_sync_q[2];
    scl_fall = ~scl_sync_q[1] & scl_sync_q[2];
    bus_start = scl_sync_q[1] & scl_sync_q[2] & ~sda_sync_q[1] & sda_sync_q[2];
    bus_stop = scl_sync_q[1] & scl_sync_q[2] & sda_sync_q[1] & ~sda_sync_q[2];
  end

  // Byte engine; reset returns it to idle with the line released
  always_ff @(posedge aclk) begin
    if (soft_rst) begin // RULE7
      state_q <= expander_pkg::ST_IDLE;
      kind_q <= expander_pkg::BK_ADDR;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      phase_q <= 1'b0;
      ack_q <= 1'b0;
      rw_q <= 1'b0;
      sda_oe <= 1'b0;
      index <= 8'h00;
      wr_stb <= 1'b0;
      wr_data <= 8'h00;
      rd_load <= 1'b0;
      rd_done <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      rd_load <= 1'b0;
      rd_done <= 1'b0;
      if (bus_start) begin
        // Start or repeated start always restarts at the address byte
        state_q <= expander_pkg::ST_RX;
        kind_q <= expander_pkg::BK_ADDR;
        cnt_q <= 3'h0;
        phase_q <= 1'b0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state_q <= expander_pkg::ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        unique case (state_q)
          expander_pkg::ST_IDLE: begin
            // Wait for a start; after a foreign address the rest of its frame stays here
          end
          expander_pkg::ST_RX: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_bit};
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == 3'h7) begin
                state_q <= expander_pkg::ST_ACK;
                phase_q <= 1'b0;
                unique case (kind_q)
                  expander_pkg::BK_ADDR: begin
                    ack_q <= (sh_q[6:0] == {ADDR_BASE[6:1], addr_select}); // RULE9 RULE11
                    rw_q <= sda_bit;
                  end
                  expander_pkg::BK_INDEX: begin
                    ack_q <= 1'b1;
                    index <= {sh_q[6:0], sda_bit}; // RULE13
                  end
                  expander_pkg::BK_DATA: begin
                    ack_q <= 1'b1;
                    wr_data <= {sh_q[6:0], sda_bit};
                    wr_stb <= 1'b1;
                  end
                  default: ack_q <= 1'b0;
                endcase
              end
            end
          end
          expander_pkg::ST_ACK: begin
            if (scl_fall && !phase_q) begin
              // Pull low through the ninth clock when acknowledging
              sda_oe <= ack_q;
              phase_q <= 1'b1;
            end else if (scl_fall) begin
              phase_q <= 1'b0;
              if (!ack_q) begin
                sda_oe <= 1'b0;
                state_q <= expander_pkg::ST_IDLE;
              end else if (kind_q == expander_pkg::BK_ADDR && rw_q) begin
                state_q <= expander_pkg::ST_TX;
                sh_q <= rd_data; // RULE6
                sda_oe <= ~rd_data[7];
                rd_load <= 1'b1;
              end else begin
                sda_oe <= 1'b0;
                state_q <= expander_pkg::ST_RX;
                kind_q <= (kind_q == expander_pkg::BK_ADDR) ? expander_pkg::BK_INDEX
                                                              : expander_pkg::BK_DATA;
              end
            end
          end
          expander_pkg::ST_TX: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], 1'b0};
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == 3'h7) begin
                state_q <= expander_pkg::ST_TXACK;
                phase_q <= 1'b0;
              end
            end else if (scl_fall) begin
              sda_oe <= ~sh_q[7];
            end
          end
          expander_pkg::ST_TXACK: begin
            if (scl_fall && !phase_q) begin
              sda_oe <= 1'b0; // Free the line for the controller
            end else if (scl_rise) begin
              // Ack or nack bit: the read counts as done here
              phase_q <= 1'b1;
              ack_q <= ~sda_bit;
              rd_done <= 1'b1; // RULE10
            end else if (scl_fall) begin
              phase_q <= 1'b0;
              if (ack_q) begin
                state_q <= expander_pkg::ST_TX;
                sh_q <= rd_data;
                sda_oe <= ~rd_data[7];
                rd_load <= 1'b1;
              end else begin
                state_q <= expander_pkg::ST_IDLE;
              end
            end
          end
        endcase
      end
    end
  end

endmodule // i2c_target_link
`default_nettype wire

// [rtl/io_expander_core.sv]
/*
  Core of an 8-bit I/O expander reached as a serial two-wire target,
  with change alert, external reset, address select and a bus slave
  that mirrors the registers and carries an interrupt unit.
  Assumes all pins are asynchronous to aclk; pad logic resolves the
  open-drain and tri-state wires from the enables.
*/
// Contract
// RULE1: Four 8-bit per-pin registers
// RULE2: All pins are inputs after power up
// RULE3: Direction bits set each pin's direction
// RULE4: Input register samples, output register drives
// RULE5: Polarity bit inverts the reported input
// RULE6: Every register reads back its contents
// RULE7: Reset pin acts like power-on reset
// RULE8: Alert when input differs from captured value
// RULE9: Select pin picks one of two addresses
// RULE10: Alert clears on return or input read
// RULE11: Outputs and foreign traffic never alert
// RULE12: Output pins drive their output register bit
// RULE13: Index byte after address picks register
// RULE14: Defaults: inputs, outputs ones, no inversion
`timescale 1ns/1ps
`default_nettype none
`include "expander_params.svh"

module io_expander_core #(
  parameter int ADDR_W = 8,
  parameter int PINS = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ext_reset_n,
  input wire logic addr_select,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [PINS-1:0] expander_pins_in,
  output logic [PINS-1:0] expander_pins_out,
  output logic [PINS-1:0] expander_pins_oe,
  output logic alert_n_out,
  output logic alert_n_oe,
  output logic irq,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);

  // Reset pin synchroniser, reset only by the system reset
  logic [1:0] ext_rst_sync_q;
  logic soft_rst; // High while either reset is active
  // Pin and select synchronisers
  logic [PINS-1:0] pins_meta_q, pins_sync_q;
  logic [1:0] sel_sync_q;
  // The three writable expander registers, then alert capture state
  logic [PINS-1:0] direction_q; // 1 = input
  logic [PINS-1:0] output_q; // RULE1
  logic [PINS-1:0] polarity_q;
  logic [PINS-1:0] captured_q; // Raw level last reported to a reader
  logic [PINS-1:0] load_raw_q; // Raw level loaded into a read byte
  logic load_was_input_q; // That read byte was the input port
  logic capture_init_q; // First cycle after reset: take a snapshot
  // Alert and interrupt state
  logic alert_now;
  logic [`EXP_EVT_W-1:0] irq_status_q, irq_enable_q, irq_events;
  // Serial engine hand-off
  logic [7:0] link_index, link_wr_data, link_rd_data;
  logic link_wr_stb, link_rd_load, link_rd_done;
  // Bus slave bookkeeping
  logic aw_held_q, w_held_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write, clear_hit;
  logic [`EXP_EVT_W-1:0] clear_bits;

  // Reported input byte: live level with per-pin inversion
  function automatic logic [PINS-1:0] input_view(input logic [PINS-1:0] raw, input logic [PINS-1:0] inv);
    input_view = raw ^ inv; // RULE5
  endfunction

  // Register read by serial index
  function automatic logic [7:0] index_read(input logic [7:0] idx);
    unique case (idx)
      `EXP_IDX_INPUT: index_read = 8'(input_view(pins_sync_q, polarity_q)); // RULE4
      `EXP_IDX_OUTPUT: index_read = 8'(output_q);
      `EXP_IDX_POLARITY: index_read = 8'(polarity_q);
      `EXP_IDX_DIRECTION: index_read = 8'(direction_q);
      default: index_read = 8'h00;
    endcase
  endfunction

  // Reset pin passes two flops before it can reset anything
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_rst_sync_q <= 2'h0;
    end else begin
      ext_rst_sync_q <= {ext_rst_sync_q[0], ext_reset_n};
    end
  end

  assign soft_rst = !aresetn || !ext_rst_sync_q[1]; // RULE7

  // Pins run free so the post-reset snapshot sees live levels, not zeros
  always_ff @(posedge aclk) begin
    pins_meta_q <= expander_pins_in;
    pins_sync_q <= pins_meta_q;
    if (soft_rst) begin
      sel_sync_q <= 2'h0;
    end else begin
      sel_sync_q <= {sel_sync_q[0], addr_select};
    end
  end

  // Serial target engine
  i2c_target_link #(
    .ADDR_BASE(`EXP_ADDR_BASE)
  ) u_link (
    .aclk(aclk),
    .soft_rst(soft_rst),
    .scl(scl),
    .sda_in(sda_in),
    .addr_select(sel_sync_q[1]),
    .rd_data(link_rd_data),
    .sda_oe(sda_oe),
    .index(link_index),
    .wr_stb(link_wr_stb),
    .wr_data(link_wr_data),
    .rd_load(link_rd_load),
    .rd_done(link_rd_done)
  );

  always_comb link_rd_data = index_read(link_index); // RULE6 RULE13

  // Writable registers; the input port ignores writes
  always_ff @(posedge aclk) begin
    if (soft_rst) begin // RULE14
      direction_q <= PINS'(`EXP_RST_DIRECTION); // RULE2
      output_q <= PINS'(`EXP_RST_OUTPUT);
      polarity_q <= PINS'(`EXP_RST_POLARITY);
    end else if (link_wr_stb) begin
      unique case (link_index)
        `EXP_IDX_OUTPUT: output_q <= PINS'(link_wr_data);
        `EXP_IDX_POLARITY: polarity_q <= PINS'(link_wr_data);
        `EXP_IDX_DIRECTION: direction_q <= PINS'(link_wr_data); // RULE3
        default: ;
      endcase
    end
  end

  // Pin drivers; an input pin is left floating
  always_ff @(posedge aclk) begin
    if (soft_rst) begin
      expander_pins_oe <= '0;
      expander_pins_out <= PINS'(`EXP_RST_OUTPUT);
    end else begin
      expander_pins_oe <= ~direction_q; // RULE12 RULE3
      expander_pins_out <= output_q; // RULE12 RULE4
    end
  end

  // Remember the raw level sent in each read byte
  always_ff @(posedge aclk) begin
    if (soft_rst) begin
      load_raw_q <= '0;
      load_was_input_q <= 1'b0;
    end else if (link_rd_load) begin
      load_raw_q <= pins_sync_q;
      load_was_input_q <= (link_index == `EXP_IDX_INPUT);
    end
  end

  // Captured level: taken after reset and at the ack slot of an input read.
  // The stored level is the one sent in the byte, so a change after the byte was loaded still alerts.
  always_ff @(posedge aclk) begin
    if (soft_rst) begin
      captured_q <= '0;
      capture_init_q <= 1'b1;
    end else if (capture_init_q) begin
      captured_q <= pins_sync_q;
      capture_init_q <= 1'b0;
    end else if (link_rd_done && load_was_input_q) begin
      captured_q <= load_raw_q; // RULE10
    end
  end

  // Alert: inputs only, and it drops by itself when the pin returns
  assign alert_now = !capture_init_q && |((pins_sync_q ^ captured_q) & direction_q); // RULE8 RULE10 RULE11

  // Open-drain alert; enable high pulls the line low
  always_ff @(posedge aclk) begin
    if (soft_rst) begin
      alert_n_oe <= 1'b0;
      alert_n_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      alert_n_oe <= alert_now; // RULE8
      alert_n_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  // Interrupt events: new alert, serial write, serial read done
  always_comb begin
    irq_events = '0;
    irq_events[`EXP_EVT_ALERT] = alert_now & ~alert_n_oe;
    irq_events[`EXP_EVT_WRITE] = link_wr_stb;
    irq_events[`EXP_EVT_READ] = link_rd_done;
  end

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (soft_rst) begin
      irq_status_q <= '0;
    end else begin
      irq_status_q <= (irq_status_q & ~clear_bits) | irq_events;
    end
  end

  // Level interrupt from enabled status bits
  always_ff @(posedge aclk) begin
    if (soft_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_status_q & ~clear_bits) | irq_events) & irq_enable_q);
    end
  end

  // Write address and data are taken in either order
  assign do_write = aw_held_q && w_held_q && !bvalid;
  assign clear_hit = do_write && aw_addr_q == ADDR_W'(`EXP_OFS_IRQ_CLEAR) && w_strb_q[0];
  assign clear_bits = clear_hit ? w_data_q[`EXP_EVT_W-1:0] : '0;

  // Write channels and response; system reset only, so the pin reset never eats a handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
      bvalid <= 1'b0;
      bresp <= `EXP_RESP_OKAY;
      irq_enable_q <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
        wready <= 1'b0;
      end
      if (do_write) begin
        bvalid <= 1'b1;
        // Only enable and clear are writable from this side
        if (aw_addr_q == ADDR_W'(`EXP_OFS_IRQ_ENABLE)) begin
          bresp <= `EXP_RESP_OKAY;
          if (w_strb_q[0]) begin
            irq_enable_q <= w_data_q[`EXP_EVT_W-1:0];
          end
        end else if (aw_addr_q == ADDR_W'(`EXP_OFS_IRQ_CLEAR)) begin
          bresp <= `EXP_RESP_OKAY;
        end else begin
          bresp <= `EXP_RESP_SLVERR;
        end
      end
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read channel: one cycle from address to data; system reset only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `EXP_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= `EXP_RESP_OKAY;
      unique case (araddr)
        ADDR_W'(`EXP_OFS_INPUT): rdata <= 32'(index_read(`EXP_IDX_INPUT));
        ADDR_W'(`EXP_OFS_OUTPUT): rdata <= 32'(index_read(`EXP_IDX_OUTPUT));
        ADDR_W'(`EXP_OFS_POLARITY): rdata <= 32'(index_read(`EXP_IDX_POLARITY));
        ADDR_W'(`EXP_OFS_DIRECTION): rdata <= 32'(index_read(`EXP_IDX_DIRECTION));
        ADDR_W'(`EXP_OFS_IRQ_STATUS): rdata <= 32'(irq_status_q);
        ADDR_W'(`EXP_OFS_IRQ_ENABLE): rdata <= 32'(irq_enable_q);
        default: begin
          // Clear register and holes read zero with an error
          rdata <= 32'h00000000;
          rresp <= `EXP_RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

endmodule // io_expander_core
`default_nettype wire

// [sim/io_expander_core_monitor.sv]
/* Checker of the expander core's pin, alert and bus port behaviour.
   Assumes binding to the core, one aclk domain, aresetn synchronous. */
`timescale 1ns/1ps
`default_nettype none
module io_expander_core_monitor #(
  parameter int PINS = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ext_reset_n,
  input wire logic scl,
  input wire logic [PINS-1:0] expander_pins_in,
  input wire logic [PINS-1:0] expander_pins_out,
  input wire logic [PINS-1:0] expander_pins_oe,
  input wire logic alert_n_out,
  input wire logic alert_n_oe,
  input wire logic irq,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Both write channels taken at one edge
  sequence s_wboth;
    awvalid && awready && wvalid && wready;
  endsequence
  // Pins and serial clock quiet long enough for any alert to settle
  sequence s_off_calm;
    (!alert_n_oe && $stable(expander_pins_in) && $stable(scl)) [*8];
  endsequence
  sequence s_on_calm;
    (alert_n_oe && $stable(expander_pins_in) && $stable(scl)) [*8];
  endsequence
  AST_RST_VALUES: assert property ($rose(aresetn) |-> expander_pins_oe == '0 && expander_pins_out == '1)
    else $error("pins not at reset defaults");
  AST_EXT_RESET: assert property (!ext_reset_n [*4] |=> expander_pins_oe == '0 && !alert_n_oe && !irq)
    else $error("reset pin did not reset");
  AST_ALERT_NEEDS_INPUT: assert property ($rose(alert_n_oe) |-> ~expander_pins_oe != '0)
    else $error("alert with no input pin");
  AST_ALERT_QUIET: assert property (s_off_calm |=> !alert_n_oe)
    else $error("alert without a cause");
  AST_ALERT_STICKY: assert property (s_on_calm |=> alert_n_oe)
    else $error("alert cleared without a cause");
  AST_ALERT_OPEN_DRAIN: assert property (alert_n_oe |-> !alert_n_out)
    else $error("alert line driven high");
  AST_WRITE_ANSWER: assert property (s_wboth |=> !awready && !wready ##1 bvalid)
    else $error("write not answered in two cycles");
  AST_B_RELEASE: assert property (bvalid && bready |=> !bvalid ##1 awready && wready)
    else $error("write response not released");
  AST_READ_ANSWER: assert property (arvalid && arready |=> rvalid && !arready && rdata[31:8] == 24'h0)
    else $error("read not answered with a byte");
  AST_R_RELEASE: assert property (rvalid && rready |=> !rvalid ##1 arready)
    else $error("read data not released");
endmodule // io_expander_core_monitor
`default_nettype wire

// [sim/i2c_ctrl_model.sv]
/* Behavioural serial bus controller: start, stop, bytes, register
   write and read frames. Assumes the bench resolves sda with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model (
  output logic scl,
  output logic sda_pull,
  input wire logic sda
);
  localparam int Q = 40;
  // Clock stands high between frames
  initial begin
    scl = 1'h1;
    sda_pull = 1'h0;
  end
  // Data set while clock low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    sda_pull = !b;
    #Q scl = 1'h1;
    #Q r = sda;
    #Q scl = 1'h0;
    #Q;
  endtask
  // Kept off the system clock edges to avoid sampling races
  task automatic start;
    #(27 - $time % 20) sda_pull = 1'h0;
    #Q scl = 1'h1;
    #Q sda_pull = 1'h1;
    #Q scl = 1'h0;
    #Q;
  endtask
  task automatic stop;
    sda_pull = 1'h1;
    #Q scl = 1'h1;
    #Q sda_pull = 1'h0;
    #Q;
  endtask
  // Byte MSB first, then the ack slot driven with m
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(m, ack);
    ack = !ack;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k;
    start();
    xfer({a, 1'h0}, 1'h1, r, ok);
    xfer(idx, 1'h1, r, k);
    xfer(d, 1'h1, r, k);
    stop();
  endtask
  // Last byte refused by the controller, as a single read ends
  task automatic rd(input logic [6:0] a, input logic [7:0] idx, output logic [7:0] d);
    logic k;
    start();
    xfer({a, 1'h0}, 1'h1, d, k);
    xfer(idx, 1'h1, d, k);
    start();
    xfer({a, 1'h1}, 1'h1, d, k);
    xfer(8'hff, 1'h1, d, k);
    stop();
  endtask
endmodule // i2c_ctrl_model
`default_nettype wire

// [sim/io_expander_core_tb_top.sv]
/* Bench of the expander core: bus tasks, serial frames, checks.
   Assumes the core, its checker and the controller model. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module io_expander_core_tb_top;
  int errors = 0;
  int total_checks = 0;
  logic aclk = 1'h0, aresetn = 1'h0, ext_reset_n = 1'h1, addr_select = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, pins = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, sda_oe, sdo, alert_n_oe, irq, scl, pull, ack;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] pout, poe, rd;
  // Open-drain data line with pull-up
  wire logic sda = !(pull || (sda_oe && !sdo));
  always #10 aclk = ~aclk;
  io_expander_core i_io_expander_core (.aclk, .aresetn, .ext_reset_n, .addr_select, .scl, .sda_in(sda),
    .sda_out(sdo), .sda_oe, .expander_pins_in(pins), .expander_pins_out(pout), .expander_pins_oe(poe),
    .alert_n_out(), .alert_n_oe, .irq, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready,
    .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
    .rvalid, .rready, .rdata, .rresp);
  i2c_ctrl_model i_i2c_ctrl_model (.scl, .sda_pull(pull), .sda);
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One clock of a bounded wait
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 60) begin
      errors++;
      close_out();
    end
  endtask
  // Address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      tick(n);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    `CHK(bresp, er)
    @(posedge aclk);
  endtask
  task automatic axr(input logic [7:0] a, input logic [7:0] ex, input logic [1:0] er);
    int n = 0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      tick(n);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    `CHK(rdata, {24'h0, ex})
    `CHK(rresp, er)
    @(posedge aclk);
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    `CHK(poe, 8'h00)
    axr(8'h04, 8'hff, 2'h0);
    axr(8'h08, 8'h00, 2'h0);
    axr(8'h0c, 8'hff, 2'h0);
    axr(8'h1c, 8'h00, 2'h2);
    axw(8'h04, 32'h0, 2'h2);
    axw(8'h14, 32'h7, 2'h0);
    // Foreign address refused; select pin low picks the lower one
    i_i2c_ctrl_model.wr(7'h21, 8'h03, 8'h00, ack);
    `CHK(ack, 1'h0)
    i_i2c_ctrl_model.wr(7'h20, 8'h03, 8'hf0, ack);
    `CHK(ack, 1'h1)
    i_i2c_ctrl_model.wr(7'h20, 8'h01, 8'h5a, ack);
    @(posedge aclk);
    `CHK(poe, 8'h0f)
    `CHK(pout, 8'h5a)
    axr(8'h0c, 8'hf0, 2'h0);
    i_i2c_ctrl_model.rd(7'h20, 8'h01, rd);
    `CHK(rd, 8'h5a)
    // Output pins follow their drive and never alert
    pins <= 8'h0a;
    repeat (10) @(posedge aclk);
    `CHK(alert_n_oe, 1'h0)
    pins <= 8'h8a;
    repeat (10) @(posedge aclk);
    `CHK(alert_n_oe, 1'h1)
    pins <= 8'h0a;
    repeat (10) @(posedge aclk);
    `CHK(alert_n_oe, 1'h0)
    pins <= 8'h4a;
    repeat (10) @(posedge aclk);
    axr(8'h00, 8'h4a, 2'h0);
    `CHK(alert_n_oe, 1'h1)
    i_i2c_ctrl_model.wr(7'h20, 8'h02, 8'h0f, ack);
    axr(8'h08, 8'h0f, 2'h0);
    axr(8'h00, 8'h45, 2'h0);
    i_i2c_ctrl_model.rd(7'h21, 8'h00, rd);
    `CHK(alert_n_oe, 1'h1)
    i_i2c_ctrl_model.rd(7'h20, 8'h00, rd);
    `CHK(rd, 8'h45)
    `CHK(alert_n_oe, 1'h0)
    // Interrupt: status sticky, masked, then cleared
    `CHK(irq, 1'h1)
    axr(8'h10, 8'h07, 2'h0);
    axw(8'h14, 32'h0, 2'h0);
    `CHK(irq, 1'h0)
    axw(8'h18, 32'h7, 2'h0);
    axw(8'h14, 32'h7, 2'h0);
    axr(8'h10, 8'h00, 2'h0);
    `CHK(irq, 1'h0)
    // Select pin high moves the device to the upper address
    addr_select <= 1'h1;
    i_i2c_ctrl_model.wr(7'h20, 8'h01, 8'h00, ack);
    `CHK(ack, 1'h0)
    i_i2c_ctrl_model.wr(7'h21, 8'h01, 8'h33, ack);
    @(posedge aclk);
    `CHK(pout, 8'h33)
    // Reset pin restores every expander register and pin default
    ext_reset_n <= 1'h0;
    repeat (4) @(posedge aclk);
    ext_reset_n <= 1'h1;
    repeat (4) @(posedge aclk);
    `CHK(poe, 8'h00)
    `CHK(pout, 8'hff)
    `CHK(alert_n_oe, 1'h0)
    axr(8'h08, 8'h00, 2'h0);
    close_out();
  end
endmodule // io_expander_core_tb_top
bind io_expander_core io_expander_core_monitor #(.PINS(PINS)) i_io_expander_core_monitor (.aclk, .aresetn,
  .ext_reset_n, .scl, .expander_pins_in, .expander_pins_out, .expander_pins_oe, .alert_n_out, .alert_n_oe,
  .irq, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .rdata);
`default_nettype wire
